/* File: rtl/nipc_pkg.sv */
// Constants, state codes and level decoding for the nested interrupt controller.
// Assumes one 50 MHz clock and a synchronous active-high reset.
package nipc_pkg;
    localparam int NVEC = 14;
    localparam int NPER = 10;
    localparam int TLI_IDX = 0;
    localparam int SUP_IDX = 3;
    localparam logic [3:0] OFS_SUPPLY_INTEGRITY_CTRL_STATUS = 4'h0;
    localparam logic [3:0] OFS_ISPR0 = 4'h1;
    localparam logic [3:0] OFS_CC = 4'h5;
    localparam logic [3:0] OFS_SENSE = 4'h6;
    localparam logic [3:0] OFS_PINSEL = 4'h7;
    localparam logic [3:0] OFS_PEND_L = 4'h8;
    localparam logic [3:0] OFS_PEND_H = 4'h9;
    localparam int BIT_SUP_EN = 6;
    localparam int BIT_PRIO_HI = 5;
    localparam int BIT_PRIO_LO = 3;
    localparam logic [1:0] PRIO_RST = 2'h3;
    localparam logic [1:0] PRIO_MAIN = 2'h2;
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP = 16'hFFFC;
    localparam logic [15:0] VEC_BASE = 16'hFFFA;
    localparam logic [13:0] HALT_WAKE_MASK = 14'h3FF7;
    localparam logic [2:0] SEL_PCL = 3'h0;
    localparam logic [2:0] SEL_CC = 3'h4;
    localparam logic [2:0] STACK_LAST = 3'h4;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_PUSH  = 3'b001,
        S_VEC   = 3'b010,
        S_POP   = 3'b011,
        S_RESET = 3'b100
    } nipc_state_t;

    // Bit pair to level number: higher number means higher priority
    function automatic logic [1:0] nipc_lvl(input logic [1:0] b);
        case (b)
            2'h2:    nipc_lvl = 2'h0;
            2'h1:    nipc_lvl = 2'h1;
            2'h0:    nipc_lvl = 2'h2;
            default: nipc_lvl = 2'h3;
        endcase
    endfunction
endpackage

/* File: rtl/nipc_arb_if.sv */
// Candidate requests and levels toward the selector, winner back.
// Assumes the selector is purely combinational.
interface nipc_arb_if;
    logic [nipc_pkg::NVEC-1:0] req;
    logic [1:0]                lvl [nipc_pkg::NVEC];
    logic [1:0]                cur_lvl;
    logic                      win_valid;
    logic [3:0]                win_idx;
    logic [1:0]                win_lvl;
    modport ctrl (output req, lvl, cur_lvl, input win_valid, win_idx, win_lvl);
    modport arb (input req, lvl, cur_lvl, output win_valid, win_idx, win_lvl);
endinterface

/* File: rtl/nipc_arbiter.sv */
// Two-step selector: software level first, then fixed hardware order.
// Assumes lower vector index means higher hardware order.
module nipc_arbiter (
    nipc_arb_if.arb arb
);
    import nipc_pkg::*;
    logic [1:0] best;
    logic [1:0] eff;
    logic [3:0] idx;
    logic       hit;

    always_comb
    begin
        best = 2'h0;
        eff  = 2'h0;
        idx  = 4'h0;
        hit  = 1'h0;
        // Scan upward in hardware order so the last tie kept is the strongest
        for (int i = NVEC - 1; i >= 0; i--)
        begin
            eff = (i == TLI_IDX) ? 2'h3 : arb.lvl[i];
            if (arb.req[i] && (eff > arb.cur_lvl) && (!hit || eff >= best))
            begin
                hit  = 1'h1;
                best = eff;
                idx  = 4'(i);
            end
        end
        arb.win_valid = hit;
        arb.win_idx   = idx;
        arb.win_lvl   = best;
    end
endmodule // nipc_arbiter

/* File: rtl/nipc_supply_mon.sv */
// Early supply-drop warning: flag, enable and pending latch.
// Assumes comparator levels are synchronous to clk_sys.
module nipc_supply_mon (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic below_low,
    input  wire logic above_high,
    input  wire logic lvd_en,
    input  wire logic halt,
    input  wire logic en_wr,
    input  wire logic en_wdata,
    input  wire logic ack,
    output logic      flag_r,
    output logic      en_r,
    output logic      pend_r
);
    logic flag_nxt;

    always_comb
    begin
        flag_nxt = flag_r;
        if (halt)
            flag_nxt = flag_r;
        else if (!lvd_en)
            flag_nxt = 1'h0;
        else if (below_low)
            flag_nxt = 1'h1;
        else if (above_high)
            flag_nxt = 1'h0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            flag_r <= 1'h0;
        else
            flag_r <= flag_nxt;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            en_r <= 1'h0;
        else if (en_wr && !halt)
            en_r <= en_wdata;
    end

    // A new rise beats the entry acknowledge in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            pend_r <= 1'h0;
        else
            pend_r <= (flag_nxt & ~flag_r & en_r) | (pend_r & ~ack);
    end

    a_flag_sets:
    assert property (@(posedge clk_sys) disable iff (reset)
        lvd_en && !halt && below_low |=> flag_r)
    else $error("drop flag not set below threshold");

    a_flag_clears:
    assert property (@(posedge clk_sys) disable iff (reset)
        lvd_en && !halt && !below_low && above_high |=> !flag_r && !$rose(pend_r))
    else $error("drop flag not cleared or request raised on recovery");

    a_flag_inactive:
    assert property (@(posedge clk_sys) disable iff (reset)
        !lvd_en && !halt |=> !flag_r)
    else $error("drop flag active without reset detector");

    a_pend_rise:
    assert property (@(posedge clk_sys) disable iff (reset)
        $rose(flag_r) && $past(en_r) |-> pend_r)
    else $error("drop request missing on flag rise");

    a_halt_frozen:
    assert property (@(posedge clk_sys) disable iff (reset)
        halt |=> $stable(flag_r) && $stable(en_r))
    else $error("status changed during halt");
endmodule // nipc_supply_mon

/* File: rtl/nipc_top.sv */
// Nested interrupt controller: latches, level register, selection and entry/return sequencing.
// Assumes the core pulses instr_end at each instruction boundary and waits while busy is high.
module nipc_top (
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    input  wire logic [3:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    input  wire logic                 instr_end,
    input  wire logic                 trap_exec,
    input  wire logic                 return_from_interrupt_exec,
    input  wire logic [7:0]           stack_pop_data,
    input  wire logic                 tli_pin,
    input  wire logic [7:0]           ext_pins,
    input  wire logic [nipc_pkg::NPER-1:0] periph_flag,
    input  wire logic [nipc_pkg::NPER-1:0] periph_en,
    input  wire logic [nipc_pkg::NPER-1:0] periph_clear,
    input  wire logic                 supply_below_low,
    input  wire logic                 supply_above_high,
    input  wire logic                 lvd_option_en,
    input  wire logic                 halt_mode,
    input  wire logic                 wait_mode,
    output logic                      stack_push,
    output logic                      stack_pop,
    output logic      [2:0]           stack_sel,
    output logic                      vec_load,
    output logic      [15:0]          vec_addr,
    output logic      [1:0]           cc_prio,
    output logic                      busy,
    output logic                      wake
);
    import nipc_pkg::*;

    nipc_arb_if  arb ();
    nipc_state_t state_r;
    logic [2:0]  cnt_r;
    logic [1:0]  prio_r [NVEC];
    logic [2:0]  sense_r;
    logic [7:0]  pinsel_r;
    logic [2:0]  ext_level;
    logic [2:0]  edge_prev_r;
    logic [2:0]  ext_latch_r;
    logic [NPER-1:0] per_latch_r;
    logic        trap_pend_r;
    logic        pop_cap_r;
    logic [1:0]  load_prio_r;
    logic        take;
    logic        return_from_interrupt_go;
    logic [13:0] ack;
    logic [15:0] vec_next;
    logic        sup_flag;
    logic        sup_en;
    logic        sup_pend;

    ////////////////////////////////////////////////////////////////////////////////
    // Sources

    // Pins of a group are ORed before the edge detector, so one edge serves all
    assign ext_level[0] = tli_pin ^ sense_r[0];
    assign ext_level[1] = (|(ext_pins[3:0] & pinsel_r[3:0])) ^ sense_r[1];
    assign ext_level[2] = (|(ext_pins[7:4] & pinsel_r[7:4])) ^ sense_r[2];

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_ext
            always_ff @(posedge clk_sys)
            begin
                if (reset)
                begin
                    edge_prev_r[gi] <= 1'h0;
                    ext_latch_r[gi] <= 1'h0;
                end
                else
                begin
                    edge_prev_r[gi] <= ext_level[gi];
                    ext_latch_r[gi] <= (ext_level[gi] & ~edge_prev_r[gi]) |
                                       (ext_latch_r[gi] & ~ack[gi]);
                end
            end
        end
        // The clearing sequence wins here: a pending request is dropped on purpose
        for (gi = 0; gi < NPER; gi++)
        begin : g_per
            always_ff @(posedge clk_sys)
            begin
                if (reset)
                    per_latch_r[gi] <= 1'h0;
                else
                    per_latch_r[gi] <= (per_latch_r[gi] | (periph_flag[gi] & periph_en[gi]))
                                       & ~periph_clear[gi];
            end
        end
    endgenerate

    nipc_supply_mon u_supply (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .below_low  (supply_below_low),
        .above_high (supply_above_high),
        .lvd_en     (lvd_option_en),
        .halt       (halt_mode),
        .en_wr      (reg_wr && reg_addr == OFS_SUPPLY_INTEGRITY_CTRL_STATUS),
        .en_wdata   (reg_wdata[BIT_SUP_EN]),
        .ack        (ack[SUP_IDX]),
        .flag_r     (sup_flag),
        .en_r       (sup_en),
        .pend_r     (sup_pend)
    );

    assign arb.req = {per_latch_r & periph_flag & periph_en, sup_pend & sup_en,
                      ext_latch_r};
    assign arb.cur_lvl = nipc_lvl(cc_prio);

    ////////////////////////////////////////////////////////////////////////////////
    // Priority registers; the main-level code cannot be stored, so a pair is kept

    generate
        for (gi = 0; gi < NVEC; gi++)
        begin : g_prio
            localparam logic [3:0] ADR = OFS_ISPR0 + 4'(gi / 4);
            localparam int         POS = 2 * (gi % 4);
            assign arb.lvl[gi] = nipc_lvl(prio_r[gi]);
            always_ff @(posedge clk_sys)
            begin
                if (reset)
                    prio_r[gi] <= PRIO_RST;
                else if (reg_wr && reg_addr == ADR && reg_wdata[POS+:2] != PRIO_MAIN)
                    prio_r[gi] <= reg_wdata[POS+:2];
            end
        end
    endgenerate

    nipc_arbiter u_arb (
        .arb (arb)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Selection

    assign take = (state_r == S_IDLE) && instr_end && !halt_mode &&
                  (trap_pend_r || arb.win_valid);
    assign return_from_interrupt_go = (state_r == S_IDLE) && return_from_interrupt_exec && !take;
    assign ack = (take && !trap_pend_r) ? (14'h0001 << arb.win_idx) : 14'h0000;
    assign vec_next = trap_pend_r ? VEC_TRAP :
                      (VEC_BASE - {11'h000, arb.win_idx, 1'h0});

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            trap_pend_r <= 1'h0;
        else
            trap_pend_r <= trap_exec | (trap_pend_r & ~take);
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            load_prio_r <= PRIO_RST;
        else if (take)
            load_prio_r <= (trap_pend_r || arb.win_idx == 4'(TLI_IDX)) ?
                           PRIO_RST : prio_r[arb.win_idx];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Entry and return sequencing

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_r    <= S_RESET;
            cnt_r      <= 3'h0;
            stack_push <= 1'h0;
            stack_pop  <= 1'h0;
            stack_sel  <= SEL_PCL;
            vec_load   <= 1'h0;
            vec_addr   <= 16'h0000;
            busy       <= 1'h1;
            pop_cap_r  <= 1'h0;
        end
        else
        begin
            pop_cap_r <= stack_pop && stack_sel == SEL_CC;
            vec_load  <= 1'h0;
            case (state_r)
                S_RESET:
                begin
                    vec_load <= 1'h1;
                    vec_addr <= VEC_RESET;
                    state_r  <= S_VEC;
                end
                S_IDLE:
                begin
                    if (take)
                    begin
                        state_r    <= S_PUSH;
                        cnt_r      <= 3'h0;
                        stack_push <= 1'h1;
                        stack_sel  <= SEL_PCL;
                        busy       <= 1'h1;
                        vec_addr   <= vec_next;
                    end
                    else if (return_from_interrupt_go)
                    begin
                        state_r   <= S_POP;
                        cnt_r     <= 3'h0;
                        stack_pop <= 1'h1;
                        stack_sel <= SEL_CC;
                        busy      <= 1'h1;
                    end
                end
                S_PUSH:
                begin
                    if (cnt_r == STACK_LAST)
                    begin
                        stack_push <= 1'h0;
                        vec_load   <= 1'h1;
                        state_r    <= S_VEC;
                    end
                    else
                    begin
                        cnt_r     <= cnt_r + 3'h1;
                        stack_sel <= cnt_r + 3'h1;
                    end
                end
                S_POP:
                begin
                    if (cnt_r == STACK_LAST)
                    begin
                        stack_pop <= 1'h0;
                        busy      <= 1'h0;
                        state_r   <= S_IDLE;
                    end
                    else
                    begin
                        cnt_r     <= cnt_r + 3'h1;
                        stack_sel <= SEL_CC - (cnt_r + 3'h1);
                    end
                end
                S_VEC:
                begin
                    busy    <= 1'h0;
                    state_r <= S_IDLE;
                end
                default:
                begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // Level bits: pop restore, entry load, then software writes standing in for
    // the mask instructions; software cannot change them mid-sequence
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            cc_prio <= PRIO_RST;
        else if (pop_cap_r)
            cc_prio <= {stack_pop_data[BIT_PRIO_HI], stack_pop_data[BIT_PRIO_LO]};
        else if (state_r == S_RESET)
            cc_prio <= PRIO_RST;
        else if (state_r == S_PUSH && cnt_r == STACK_LAST)
            cc_prio <= load_prio_r;
        else if (reg_wr && reg_addr == OFS_CC && !busy)
            cc_prio <= {reg_wdata[BIT_PRIO_HI], reg_wdata[BIT_PRIO_LO]};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration and read port

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            sense_r  <= 3'h0;
            pinsel_r <= 8'h00;
        end
        else if (reg_wr && reg_addr == OFS_SENSE)
            sense_r <= reg_wdata[2:0];
        else if (reg_wr && reg_addr == OFS_PINSEL)
            pinsel_r <= reg_wdata;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (!reg_rd)
            reg_rdata <= 8'h00;
        else
        begin
            case (reg_addr)
                OFS_SUPPLY_INTEGRITY_CTRL_STATUS:  reg_rdata <= {1'h0, sup_en, sup_flag, 5'h00};
                4'h1:       reg_rdata <= {prio_r[3], prio_r[2], prio_r[1], prio_r[0]};
                4'h2:       reg_rdata <= {prio_r[7], prio_r[6], prio_r[5], prio_r[4]};
                4'h3:       reg_rdata <= {prio_r[11], prio_r[10], prio_r[9], prio_r[8]};
                4'h4:       reg_rdata <= {4'hF, prio_r[13], prio_r[12]};
                OFS_CC:     reg_rdata <= {2'h0, cc_prio[1], 1'h0, cc_prio[0], 3'h0};
                OFS_SENSE:  reg_rdata <= {5'h00, sense_r};
                OFS_PINSEL: reg_rdata <= pinsel_r;
                OFS_PEND_L: reg_rdata <= arb.req[7:0];
                OFS_PEND_H: reg_rdata <= {2'h0, arb.req[13:8]};
                default:    reg_rdata <= 8'h00;
            endcase
        end
    end

    // Halt wake excludes the supply-drop source; every request ends Wait
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            wake <= 1'h0;
        else
            wake <= (halt_mode && |(arb.req & HALT_WAKE_MASK)) ||
                    (wait_mode && (|arb.req || trap_pend_r));
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    a_reset_vector:
    assert property (@(posedge clk_sys) $past(reset) && !reset
        |=> vec_load && vec_addr == VEC_RESET && cc_prio == PRIO_RST && !stack_push)
    else $error("reset vector not loaded at level 3");

    a_take_push:
    assert property (@(posedge clk_sys) disable iff (reset)
        take |=> stack_push [*5] ##1 (vec_load && !stack_push))
    else $error("entry did not push five bytes before vector");

    a_return_from_interrupt_restore:
    assert property (@(posedge clk_sys) disable iff (reset)
        pop_cap_r |=> cc_prio == {$past(stack_pop_data[5]), $past(stack_pop_data[3])})
    else $error("level bits not restored on return");

    a_trap_level:
    assert property (@(posedge clk_sys) disable iff (reset)
        take && trap_pend_r |=> ##5 (vec_load && vec_addr == VEC_TRAP && cc_prio == PRIO_RST))
    else $error("trap entry wrong vector or level");

    a_level_above:
    assert property (@(posedge clk_sys) disable iff (reset)
        take && !trap_pend_r |=> ##5 (nipc_lvl(cc_prio) > $past(arb.cur_lvl, 6)))
    else $error("maskable source entered without exceeding level");

    a_edge_latch:
    assert property (@(posedge clk_sys) disable iff (reset)
        ext_level[1] && !edge_prev_r[1] |=> ext_latch_r[1])
    else $error("external edge not latched");

    a_clear_drops:
    assert property (@(posedge clk_sys) disable iff (reset)
        periph_clear[0] |=> !per_latch_r[0])
    else $error("clearing sequence kept the request");

    a_vec_range:
    assert property (@(posedge clk_sys) disable iff (reset)
        vec_load |-> vec_addr[15:5] == 11'h7FF && !vec_addr[0])
    else $error("vector outside top range");

    a_no_halt_wake:
    assert property (@(posedge clk_sys) disable iff (reset)
        halt_mode && !wait_mode && (arb.req & HALT_WAKE_MASK) == 14'h0000 |=> !wake)
    else $error("supply drop woke device from halt");

    a_supply_integrity_ctrl_status_read:
    assert property (@(posedge clk_sys) disable iff (reset)
        reg_rd && reg_addr == OFS_SUPPLY_INTEGRITY_CTRL_STATUS
        |=> reg_rdata[7] == 1'h0 && reg_rdata[2:1] == 2'h0 && reg_rdata[5] == $past(sup_flag))
    else $error("status register read wrong");
endmodule // nipc_top

/* File: bench/nipc_core_model.sv */
// Core stand-in: instruction boundaries and popped condition-code byte.
// Assumes the controller pops CC first and samples it over the next two cycles.
module nipc_core_model (
    input  wire logic       clk_sys,
    input  wire logic       busy,
    input  wire logic       stack_pop,
    input  wire logic [2:0] stack_sel,
    input  wire logic [7:0] saved_cc,
    output logic            instr_end,
    output logic [7:0]      stack_pop_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic hit_r = 0;
    logic tog_r = 0;
    initial instr_end = 0;
    initial stack_pop_data = 8'h00;
    // Boundary every other cycle, never in the cycle after one with busy high
    always @(posedge clk_sys)
    begin
        tog_r <= !tog_r;
        instr_end <= !busy && tog_r;
        hit_r <= stack_pop && stack_sel == 3'h4;
        // Bus toggles outside the CC window so a late sample is caught
        stack_pop_data <= (stack_pop && stack_sel == 3'h4) || hit_r ? saved_cc
                          : ~stack_pop_data;
    end
endmodule // nipc_core_model

/* File: bench/test_nipc_top.sv */
// Self-checking bench for the nested interrupt controller.
// Assumes the core stand-in answers pops; expected results go through queues.
module test_nipc_top;
    import nipc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0, trap_exec = 0, return_from_interrupt_exec = 0;
    logic tli_pin = 0, supply_below_low = 0, supply_above_high = 0, lvd_option_en = 0;
    logic halt_mode = 0, wait_mode = 0, rd_d = 0, busy_d = 0;
    logic instr_end, stack_push, stack_pop, vec_load, busy, wake;
    logic [3:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, ext_pins = 0, reg_rdata, stack_pop_data, w, e;
    logic [NPER-1:0] periph_flag = 0, periph_en = 0, periph_clear = 0;
    logic [2:0] stack_sel;
    logic [15:0] vec_addr, lfsr = 16'hde1a;
    logic [1:0] cc_prio;
    logic [15:0] exp_vec [$];
    logic [7:0] exp_rd [$];
    logic [1:0] exp_lvl [$];
    int err_count = 0, check_count = 0;
    nipc_top DUT (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .instr_end, .trap_exec, .return_from_interrupt_exec, .stack_pop_data, .tli_pin, .ext_pins,
        .periph_flag, .periph_en, .periph_clear, .supply_below_low, .supply_above_high,
        .lvd_option_en, .halt_mode, .wait_mode, .stack_push, .stack_pop, .stack_sel,
        .vec_load, .vec_addr, .cc_prio, .busy, .wake);
    nipc_core_model core (.clk_sys, .busy, .stack_pop, .stack_sel, .saved_cc(8'h20),
        .instr_end, .stack_pop_data);
    always #10 clk_sys = !clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want)
        begin
            err_count++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic wrap_up();
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Gap cycle before each strobe keeps one assignment per time step
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 0;
        reg_rd <= 0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] d);
        exp_rd.push_back(d);
        bus(0, a, 8'h00);
    endtask
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Return from a routine; the stand-in core always hands back a main-level CC
    task automatic ret();
        exp_lvl.push_back(2'h2);
        return_from_interrupt_exec <= 1;
        @(posedge clk_sys);
        return_from_interrupt_exec <= 0;
        settle();
    endtask
    task automatic settle();
        repeat (6) @(posedge clk_sys);
        for (int n = 0; busy && n < 60; n++)
            @(posedge clk_sys);
        if (busy)
        begin
            err_count++;
            wrap_up();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys)
    begin
        rd_d <= reg_rd;
        busy_d <= busy;
        if (rd_d && exp_rd.size() > 0)
            chk(16'(reg_rdata), 16'(exp_rd.pop_front()));
        if (vec_load && exp_vec.size() > 0)
            chk(vec_addr, exp_vec.pop_front());
        if (busy_d && !busy && exp_lvl.size() > 0)
            chk(16'(cc_prio), 16'(exp_lvl.pop_front()));
    end
    initial
    begin
        #200000;
        err_count++;
        wrap_up();
    end
    initial
    begin
        exp_vec.push_back(VEC_RESET);
        exp_lvl.push_back(PRIO_RST);
        repeat (5) @(posedge clk_sys);
        reset <= 0;
        settle();
        lfsr = lfsr_next(lfsr);
        w = lfsr[7:0];
        e = w;
        // Main-level pair cannot be stored: old value kept
        for (int i = 0; i < 4; i++)
            if (w[2*i+:2] == 2'h2)
                e[2*i+:2] = 2'h3;
        bus(1, OFS_ISPR0, w);
        rd(OFS_ISPR0, e);
        bus(1, OFS_CC, 8'h20);
        bus(1, OFS_SUPPLY_INTEGRITY_CTRL_STATUS, 8'hff);
        supply_below_low <= 1;
        rd(OFS_SUPPLY_INTEGRITY_CTRL_STATUS, 8'h40);
        exp_vec.push_back(16'hfff4);
        exp_lvl.push_back(e[7:6]);
        lvd_option_en <= 1;
        settle();
        rd(OFS_SUPPLY_INTEGRITY_CTRL_STATUS, 8'h60);
        exp_lvl.push_back(2'h2);
        return_from_interrupt_exec <= 1;
        @(posedge clk_sys);
        return_from_interrupt_exec <= 0;
        settle();
        supply_below_low <= 0;
        supply_above_high <= 1;
        rd(OFS_SUPPLY_INTEGRITY_CTRL_STATUS, 8'h40);
        rd(4'ha, 8'h00);
        trap_exec <= 1;
        exp_vec.push_back(VEC_TRAP);
        exp_lvl.push_back(PRIO_RST);
        @(posedge clk_sys);
        trap_exec <= 0;
        settle();
        ret();
        bus(1, OFS_PINSEL, 8'h01);
        ext_pins <= 8'h01;
        exp_vec.push_back(16'hfff8);
        exp_lvl.push_back(e[3:2]);
        settle();
        ret();
        // Level 3 holds the peripheral request pending until unmasked
        bus(1, OFS_CC, 8'h28);
        periph_flag[0] <= 1'b1;
        periph_en[0] <= 1'b1;
        rd(OFS_PEND_L, 8'h10);
        exp_vec.push_back(16'hfff2);
        exp_lvl.push_back(2'h3);
        bus(1, OFS_CC, 8'h20);
        settle();
        periph_flag[0] <= 1'b0;
        periph_clear[0] <= 1'b1;
        @(posedge clk_sys);
        periph_clear[0] <= 1'b0;
        ret();
        rd(OFS_PEND_L, 8'h00);
        // Masked supply-drop request: no Halt wake, but Wait wake
        bus(1, OFS_CC, 8'h28);
        supply_above_high <= 0;
        supply_below_low <= 1;
        repeat (3) @(posedge clk_sys);
        halt_mode <= 1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(16'(wake), 16'h0000);
        @(posedge clk_sys);
        halt_mode <= 0;
        wait_mode <= 1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(16'(wake), 16'h0001);
        repeat (3) @(posedge clk_sys);
        wrap_up();
    end
endmodule // test_nipc_top
